//--- hw/otppv_ctrl.v
// programmer-side controller driving an otp program/verify port
// Overview of operation
// - idle: chip select high, reset low, select low, test pin high, pulse high
// - test pin low selects program, high selects verify
// - raise mode activate after selecting program mode
// - present address on bus and upper port while reset low
// - raise reset once address stable to latch it
// - drive data, then one 100 us low pulse on the program pin
// - after each pulse go to verify, compare, then back to program
// - finish each byte fully before the next address
// - each attempt is one pulse then one verification
// - at most 25 pulses per byte, then the byte fails
// - optional final read-back pass compares every byte
// - verify: test, pulse, single-step, chip select high, select low, activate high
// - watch the sync clock and refuse to start a byte without it
`timescale 1ns/1ns
`include "otppv_defs.vh"
module otppv_ctrl #(
  parameter PULSE_CYC = `OTPPV_PULSE_CYC,
  parameter SETUP_CYC = `OTPPV_SETUP_CYC,
  parameter SYNC_WIN  = `OTPPV_SYNC_WIN_CYC,
  parameter MAX_PULSE = `OTPPV_MAX_PULSES
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // user side: words of {verify_only, address, data}
  input  wire [20:0] wr_data_i,
  input  wire        wr_valid_i,
  output wire        wr_ready_o,
  output reg  [1:0]  status_o,
  output reg  [11:0] fail_addr_o,
  output reg  [7:0]  fail_data_o,
  output reg         byte_done_o,
  input  wire        clear_i,
  // device pins
  output reg         chip_sel_n_o,
  output reg         dev_reset_n_o,
  output reg         register_select_o,
  output reg         program_verify_select_pin_o,
  output reg         mode_activate_pin_o,
  output reg         prog_pulse_n_o,
  output reg         single_step_n_o,
  output reg  [3:0]  upper_address_port_o,
  output reg  [7:0]  bus_o,
  output reg         bus_oe_o,
  input  wire [7:0]  bus_i,
  input  wire        sync_clk_i
);
  // =====================================================
  // states
  localparam S_IDLE   = 4'h0;
  localparam S_SEL    = 4'h1;
  localparam S_ACT    = 4'h2;
  localparam S_ADDR   = 4'h3;
  localparam S_LATCH  = 4'h4;
  localparam S_DATA   = 4'h5;
  localparam S_PULSE  = 4'h6;
  localparam S_VSEL   = 4'h7;
  localparam S_VCMP   = 4'h8;
  localparam S_NEXT   = 4'h9;
  localparam S_FAIL   = 4'ha;
  localparam S_NOSYNC = 4'hb;

  reg  [3:0]  state;
  reg  [15:0] timer;
  reg  [4:0]  pulses;
  reg  [7:0]  bus_s1;
  reg  [7:0]  bus_s2;
  reg         sync_s1;
  reg         sync_s2;
  reg         sync_d;
  reg  [15:0] sync_age;
  reg         cur_vonly;
  reg  [11:0] cur_addr;
  reg  [7:0]  cur_data;
  wire [20:0] q_data;
  wire        q_valid;
  reg         q_ready;
  wire        sync_ok;
  wire        timer_done;

  // =====================================================
  // buffer of pending bytes; stalls the user when full
  otppv_fifo #(
    .W  (21),
    .D  (`OTPPV_FIFO_DEPTH),
    .AW (4)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (wr_data_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .out_data_o  (q_data),
    .out_valid_o (q_valid),
    .out_ready_i (q_ready)
  );

  // =====================================================
  // pin synchronisers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_s1  <= 8'h00;
      bus_s2  <= 8'h00;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_d  <= 1'b0;
    end else if (ce_i) begin
      bus_s1  <= bus_i;
      bus_s2  <= bus_s1;
      sync_s1 <= sync_clk_i;
      sync_s2 <= sync_s1;
      sync_d  <= sync_s2;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_age <= 16'hffff;
    end else if (ce_i) begin
      if (sync_s2 != sync_d) begin
        sync_age <= 16'h0000;
      end else if (sync_age != 16'hffff) begin
        sync_age <= sync_age + 16'h0001;
      end
    end
  end
  assign sync_ok    = (sync_age < SYNC_WIN[15:0]);
  assign timer_done = (timer == 16'h0000);

  always @* begin
    q_ready = ce_i && (state == S_IDLE) && sync_ok;
  end

  // =====================================================
  // sequencer
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                       <= S_IDLE;
      timer                       <= 16'h0000;
      pulses                      <= 5'h00;
      cur_vonly                   <= 1'b0;
      cur_addr                    <= 12'h000;
      cur_data                    <= 8'h00;
      status_o                    <= `OTPPV_ST_IDLE;
      fail_addr_o                 <= 12'h000;
      fail_data_o                 <= 8'h00;
      byte_done_o                 <= 1'b0;
      chip_sel_n_o                <= 1'b1;
      dev_reset_n_o               <= 1'b0;
      register_select_o           <= 1'b0;
      program_verify_select_pin_o <= 1'b1;
      mode_activate_pin_o         <= 1'b0;
      prog_pulse_n_o              <= 1'b1;
      single_step_n_o             <= 1'b1;
      upper_address_port_o        <= 4'h0;
      bus_o                       <= 8'h00;
      bus_oe_o                    <= 1'b0;
    end else if (ce_i) begin
      byte_done_o <= 1'b0;
      if (!timer_done) begin
        timer <= timer - 16'h0001;
      end
      case (state)
        S_IDLE: begin
          chip_sel_n_o                <= 1'b1;
          dev_reset_n_o               <= 1'b0;
          register_select_o           <= 1'b0;
          program_verify_select_pin_o <= 1'b1;
          prog_pulse_n_o              <= 1'b1;
          bus_oe_o                    <= 1'b0;
          if (clear_i) begin
            status_o <= `OTPPV_ST_IDLE;
          end
          if (q_valid && !sync_ok) begin
            status_o <= `OTPPV_ST_NOSYNC;
          end else if (q_valid) begin
            {cur_vonly, cur_addr, cur_data} <= q_data;
            pulses   <= 5'h00;
            status_o <= `OTPPV_ST_BUSY;
            timer    <= SETUP_CYC[15:0];
            state    <= S_SEL;
          end
        end
        S_SEL: begin
          // program select low before activate, read-back too
          program_verify_select_pin_o <= 1'b0;
          if (timer_done) begin
            timer <= SETUP_CYC[15:0];
            state <= S_ACT;
          end
        end
        S_ACT: begin
          // activate after select; held for all accesses
          mode_activate_pin_o <= 1'b1;
          if (timer_done) begin
            timer <= SETUP_CYC[15:0];
            state <= S_ADDR;
          end
        end
        S_ADDR: begin
          // address with reset low; bank bit on port bit 3
          dev_reset_n_o        <= 1'b0;
          bus_o                <= cur_addr[7:0];
          upper_address_port_o <= cur_addr[`OTPPV_BANK_BIT:8];
          bus_oe_o             <= 1'b1;
          if (timer_done) begin
            timer <= SETUP_CYC[15:0];
            state <= S_LATCH;
          end
        end
        S_LATCH: begin
          dev_reset_n_o <= 1'b1;
          if (timer_done) begin
            timer <= SETUP_CYC[15:0];
            state <= cur_vonly ? S_VSEL : S_DATA;
          end
        end
        S_DATA: begin
          program_verify_select_pin_o <= 1'b0;
          bus_o                       <= cur_data;
          bus_oe_o                    <= 1'b1;
          if (timer_done) begin
            // one low pulse of the full width
            prog_pulse_n_o <= 1'b0;
            timer          <= PULSE_CYC[15:0] - 16'h0001;
            pulses         <= pulses + 5'h01;
            state          <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (timer_done) begin
            prog_pulse_n_o <= 1'b1;
            timer          <= SETUP_CYC[15:0];
            state          <= S_VSEL;
          end
        end
        S_VSEL: begin
          // verify after every pulse; verify pin levels
          bus_oe_o                    <= 1'b0;
          program_verify_select_pin_o <= 1'b1;
          prog_pulse_n_o              <= 1'b1;
          single_step_n_o             <= 1'b1;
          chip_sel_n_o                <= 1'b1;
          register_select_o           <= 1'b0;
          mode_activate_pin_o         <= 1'b1;
          // bus is sampled through two flops, so wait past them
          if (timer_done) begin
            timer <= 16'h0002;
            state <= S_VCMP;
          end
        end
        S_VCMP: begin
          if (timer_done) begin
            timer <= SETUP_CYC[15:0];
            if (bus_s2 == cur_data) begin
              byte_done_o <= 1'b1;
              state       <= S_NEXT;
            end else if (cur_vonly || pulses == MAX_PULSE[4:0]) begin
              fail_addr_o <= cur_addr;
              fail_data_o <= bus_s2;
              status_o    <= `OTPPV_ST_FAIL;
              state       <= S_FAIL;
            end else begin
              state <= S_DATA;
            end
          end
        end
        S_NEXT: begin
          // byte finished, drop reset for next address
          program_verify_select_pin_o <= 1'b0;
          dev_reset_n_o               <= 1'b0;
          if (timer_done) begin
            status_o <= `OTPPV_ST_IDLE;
            state    <= S_IDLE;
          end
        end
        S_FAIL: begin
          // halt; fifo stays held until software clears
          dev_reset_n_o       <= 1'b0;
          mode_activate_pin_o <= 1'b0;
          bus_oe_o            <= 1'b0;
          if (clear_i) begin
            status_o <= `OTPPV_ST_IDLE;
            state    <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // otppv_ctrl

//--- hw/otppv_defs.vh
// constants for the otp program/verify controller
`ifndef OTPPV_DEFS_VH
`define OTPPV_DEFS_VH
// =====================================================
// timing
`define OTPPV_CLK_HZ          10000000
`define OTPPV_PULSE_US        100
`define OTPPV_PULSE_CYC       ((`OTPPV_PULSE_US * (`OTPPV_CLK_HZ / 1000000)))
`define OTPPV_SETUP_CYC       4
`define OTPPV_SYNC_WIN_CYC    64
// =====================================================
// limits and layout
`define OTPPV_MAX_PULSES      25
`define OTPPV_ADDR_W          12
`define OTPPV_BANK_BIT        11
`define OTPPV_DATA_W          8
`define OTPPV_FIFO_DEPTH      16
// =====================================================
// status codes
`define OTPPV_ST_IDLE         2'h0
`define OTPPV_ST_BUSY         2'h1
`define OTPPV_ST_FAIL         2'h2
`define OTPPV_ST_NOSYNC       2'h3
`endif

//--- hw/otppv_fifo.v
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/1ns
module otppv_fifo #(
  parameter W  = 20,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          ce_i,
  input  wire [W-1:0]  in_data_i,
  input  wire          in_valid_i,
  output wire          in_ready_o,
  output wire [W-1:0]  out_data_o,
  output wire          out_valid_o,
  input  wire          out_ready_i
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         push;
  wire         pop;
  assign in_ready_o  = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = (p == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // otppv_fifo

//--- testbench/otppv_dev_model.sv
// behavioural otp device seen from its program/verify pins
`timescale 1ns/1ns
module otppv_dev_model (
  input  wire       clk_i,
  input  wire       sync_en_i,
  input  wire [5:0] need_i,
  input  wire       dev_reset_n_i,
  input  wire       pv_select_i,
  input  wire       activate_i,
  input  wire       prog_pulse_n_i,
  input  wire [3:0] upper_i,
  input  wire [7:0] ctrl_bus_i,
  input  wire       ctrl_oe_i,
  output wire [7:0] bus_o,
  output reg        sync_o
);
  reg  [7:0]  mem [0:4095];
  reg  [11:0] addr;
  reg  [5:0]  pcnt;
  reg  [7:0]  last;
  reg  [7:0]  data;
  wire        rd;
  integer     i;
  initial begin
    for (i = 0; i < 4096; i = i + 1) mem[i] = 8'hff;
    sync_o = 1'b0;
    last = 8'h00;
    pcnt = 6'h00;
    addr = 12'h000;
  end
  always @(posedge clk_i) sync_o <= sync_en_i ? ~sync_o : sync_o;
  always @(posedge dev_reset_n_i) begin
    if (activate_i) begin
      addr <= {upper_i, bus_o};
      pcnt <= 6'h00;
    end
  end
  always @(negedge prog_pulse_n_i) data <= bus_o;
  always @(posedge prog_pulse_n_i) begin
    if (!pv_select_i && activate_i && dev_reset_n_i) begin
      pcnt <= pcnt + 6'h01;
      if (pcnt + 6'h01 >= need_i) mem[addr] <= mem[addr] & data;
    end
  end
  assign rd = pv_select_i && activate_i && dev_reset_n_i && !ctrl_oe_i;
  // floating bus shows a changing pattern, not the old byte
  assign bus_o = ctrl_oe_i ? ctrl_bus_i : (rd ? mem[addr] : ~last);
  always @(posedge clk_i) last <= bus_o;
endmodule // otppv_dev_model

//--- testbench/otppv_ctrl_sva.sv
// pin-level assertions for the otp program/verify controller
`timescale 1ns/1ns
module otppv_ctrl_sva #(
  parameter PULSE_CYC = 1000,
  parameter MAX_PULSE = 25
) (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire [1:0] status_o,
  input wire       chip_sel_n_o,
  input wire       dev_reset_n_o,
  input wire       register_select_o,
  input wire       program_verify_select_pin_o,
  input wire       mode_activate_pin_o,
  input wire       prog_pulse_n_o,
  input wire       single_step_n_o,
  input wire [3:0] upper_address_port_o,
  input wire       bus_oe_o
);
  reg [15:0] low_cnt;
  reg [7:0]  pulse_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // =====================================================
  // helper counters
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 16'h0000;
      pulse_cnt <= 8'h00;
    end else begin
      low_cnt <= prog_pulse_n_o ? 16'h0000 : low_cnt + 16'h0001;
      if (!dev_reset_n_o) pulse_cnt <= 8'h00;
      else if ($fell(prog_pulse_n_o)) pulse_cnt <= pulse_cnt + 8'h01;
    end
  end
  // =====================================================
  // assertions
  chk_idle_pins_reset: assert property ($rose(rst_n_i) |-> chip_sel_n_o && !dev_reset_n_o
    && program_verify_select_pin_o && prog_pulse_n_o && !bus_oe_o && !register_select_o)
    else $error("pins not idle after reset");
  chk_pulse_in_program: assert property (!prog_pulse_n_o |-> !program_verify_select_pin_o
    && mode_activate_pin_o && dev_reset_n_o && bus_oe_o)
    else $error("pulse outside program mode");
  chk_pulse_width: assert property ($rose(prog_pulse_n_o) |-> low_cnt == PULSE_CYC)
    else $error("program pulse width wrong");
  chk_pulse_limit: assert property (pulse_cnt <= MAX_PULSE)
    else $error("too many pulses on one byte");
  chk_latch_addr: assert property ($rose(dev_reset_n_o) |-> $past(bus_oe_o)
    && !program_verify_select_pin_o && mode_activate_pin_o)
    else $error("address latched without address driven");
  chk_verify_pins: assert property (program_verify_select_pin_o && dev_reset_n_o
    && status_o != 2'h2 |-> prog_pulse_n_o && chip_sel_n_o && single_step_n_o
    && !register_select_o && mode_activate_pin_o && !bus_oe_o)
    else $error("verify pin levels wrong");
  chk_nosync_refuse: assert property (status_o == 2'h3 |-> prog_pulse_n_o && !dev_reset_n_o)
    else $error("programming without sync clock");
  chk_addr_held: assert property (dev_reset_n_o && $past(dev_reset_n_o)
    |-> $stable(upper_address_port_o))
    else $error("upper address moved while latched");
endmodule // otppv_ctrl_sva
bind otppv_ctrl otppv_ctrl_sva #(.PULSE_CYC(PULSE_CYC), .MAX_PULSE(MAX_PULSE)) u_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .status_o(status_o), .chip_sel_n_o(chip_sel_n_o),
  .dev_reset_n_o(dev_reset_n_o), .register_select_o(register_select_o),
  .program_verify_select_pin_o(program_verify_select_pin_o),
  .mode_activate_pin_o(mode_activate_pin_o), .prog_pulse_n_o(prog_pulse_n_o),
  .single_step_n_o(single_step_n_o), .upper_address_port_o(upper_address_port_o),
  .bus_oe_o(bus_oe_o));

//--- testbench/otppv_ctrl_test.sv
// self-checking bench for the otp program/verify controller
`timescale 1ns/1ns
module otppv_ctrl_test;
  reg         clk, rst_n, wr_valid, clear, sync_en;
  reg  [20:0] wr_data;
  reg  [5:0]  need;
  wire        wr_ready, byte_done, cs_n, drst_n, rsel, pvs, act, pls_n, step_n, oe, sync;
  wire [1:0]  status;
  wire [11:0] fail_addr;
  wire [7:0]  fail_data, bus_d, bus_w;
  wire [3:0]  upper;
  integer     num_errors, checks, n, k;
  otppv_ctrl #(.PULSE_CYC(20)) DUT (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .wr_data_i(wr_data), .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready), .status_o(status), .fail_addr_o(fail_addr),
    .fail_data_o(fail_data), .byte_done_o(byte_done), .clear_i(clear),
    .chip_sel_n_o(cs_n), .dev_reset_n_o(drst_n), .register_select_o(rsel),
    .program_verify_select_pin_o(pvs), .mode_activate_pin_o(act), .prog_pulse_n_o(pls_n),
    .single_step_n_o(step_n), .upper_address_port_o(upper), .bus_o(bus_d), .bus_oe_o(oe),
    .bus_i(bus_w), .sync_clk_i(sync));
  otppv_dev_model dev (
    .clk_i(clk), .sync_en_i(sync_en), .need_i(need), .dev_reset_n_i(drst_n),
    .pv_select_i(pvs), .activate_i(act), .prog_pulse_n_i(pls_n), .upper_i(upper),
    .ctrl_bus_i(bus_d), .ctrl_oe_i(oe), .bus_o(bus_w), .sync_o(sync));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task check(input [255:0] name, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
        num_errors = num_errors + 1;
      end
    end
  endtask
  task timeout;
    begin
      num_errors = num_errors + 1;
      end_sim;
    end
  endtask
  task push(input [20:0] w);
    begin
      @(negedge clk);
      wr_data = w;
      wr_valid = 1'b1;
      for (n = 0; n < 50 && wr_ready !== 1'b1; n = n + 1) @(negedge clk);
      if (n == 50) timeout;
      @(negedge clk);
      wr_valid = 1'b0;
    end
  endtask
  task wait_done(input integer cnt);
    begin
      k = 0;
      for (n = 0; n < 20000 && k < cnt; n = n + 1) begin
        @(negedge clk);
        if (byte_done === 1'b1) k = k + 1;
      end
      if (k < cnt) timeout;
    end
  endtask
  task t_reset;
    begin
      check("idle pins", 8'b10010100, {cs_n, drst_n, rsel, pvs, act, pls_n, oe, status[0]});
      $display("t_reset done");
    end
  endtask
  task t_nosync;
    begin
      sync_en = 1'b0;
      // let the watchdog expire first, or the word is taken at once
      repeat (80) @(negedge clk);
      push({1'b0, 12'h8a5, 8'h3c});
      repeat (80) @(negedge clk);
      check("status nosync", 2'h3, status);
      check("reset pin held", 1'b0, drst_n);
      $display("t_nosync done");
    end
  endtask
  task t_prog;
    begin
      need = 6'd3;
      sync_en = 1'b1;
      wait_done(1);
      // status returns to idle only after the next-byte state
      repeat (8) @(negedge clk);
      check("upper bank byte", 8'h3c, dev.mem[12'h8a5]);
      check("lower bank byte", 8'hff, dev.mem[12'h0a5]);
      check("pulses used", 6'd3, dev.pcnt);
      check("status ok", 2'h0, status);
      $display("t_prog done");
    end
  endtask
  task t_fail;
    begin
      need = 6'd30;
      push({1'b0, 12'h123, 8'h00});
      for (n = 0; n < 5000 && status !== 2'h2; n = n + 1) @(negedge clk);
      if (n == 5000) timeout;
      check("pulse limit", 6'd25, dev.pcnt);
      check("fail address", 12'h123, fail_addr);
      check("fail data", 8'hff, fail_data);
      @(negedge clk);
      clear = 1'b1;
      @(negedge clk);
      clear = 1'b0;
      @(negedge clk);
      check("status cleared", 2'h0, status);
      $display("t_fail done");
    end
  endtask
  task t_verify;
    begin
      push({1'b1, 12'h8a5, 8'h3c});
      wait_done(1);
      repeat (8) @(negedge clk);
      check("no pulse on readback", 6'd0, dev.pcnt);
      check("readback status", 2'h0, status);
      $display("t_verify done");
    end
  endtask
  task t_fill;
    integer i;
    begin
      sync_en = 1'b0;
      repeat (80) @(negedge clk);
      for (i = 0; i < 16; i = i + 1) push({1'b1, i[11:0], 8'hff});
      @(negedge clk);
      wr_data = {1'b1, 12'h010, 8'hff};
      wr_valid = 1'b1;
      repeat (3) @(negedge clk);
      check("full refuses", 1'b0, wr_ready);
      wr_valid = 1'b0;
      sync_en = 1'b1;
      wait_done(16);
      // a refused word that slipped in would show as a seventeenth byte
      for (n = 0; n < 60; n = n + 1) begin
        @(negedge clk);
        if (byte_done === 1'b1) k = k + 1;
      end
      check("drained count", 16, k);
      $display("t_fill done");
    end
  endtask
  initial begin
    num_errors = 0;
    checks = 0;
    rst_n = 1'b0;
    wr_valid = 1'b0;
    wr_data = 21'h000000;
    clear = 1'b0;
    sync_en = 1'b1;
    need = 6'd1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset;
    t_nosync;
    t_prog;
    t_fail;
    t_verify;
    t_fill;
    end_sim;
  end
endmodule // otppv_ctrl_test
